//--- rtl/dpt_pkg.sv
// Constants, register map and carrier types of the dual output PWM timer.
// Assumes a classic Wishbone bus with 32-bit data and byte addresses.
//
// Overview of operation
// - Both counters and three reload registers are zero at reset.
// - Timer clock is 32 kHz by default, fast clocks need select and enable.
// - Divide-by-ten option slows only the countdown counter.
// - Run bit starts timer: interrupt, load both counters, then decrement.
// - Cycle counter at zero toggles phase and reloads other phase shadow.
// - Primary output high in high phase; second output always inverted.
// - Clocked mode gives half-rate square wave during the high phase.
// - Countdown waits at zero until cycle counter ends low phase; interrupt.
// - End of cycle reloads countdown, cycle counter and both shadows.
// - Reload writes reach shadows only at the end of a cycle.
// - Start-up state counts as end of cycle, so interrupt at start-up.
// - Disabled timer held in reset; reload registers keep their contents.
// - Reading interval reload address returns live countdown counter.
// - Reading either phase reload address returns live cycle counter.
// - Freeze bit stops both counters and holds all timer state.
// - Writing reset-freeze clears freeze; counting resumes from held state.
// - Fast timer clock is system clock divided by 1, 2, 4 or 8.
package dpt_pkg;

   // -----------------------------------------------------------------
   // Register map, byte addresses.
   // -----------------------------------------------------------------
   localparam logic [7:0] DPT_ADR_HIGH_RELOAD = 8'h00;
   localparam logic [7:0] DPT_ADR_LOW_RELOAD  = 8'h04;
   localparam logic [7:0] DPT_ADR_IVL_RELOAD  = 8'h08;
   localparam logic [7:0] DPT_ADR_CONTROL     = 8'h0C;
   localparam logic [7:0] DPT_ADR_CLK_CFG     = 8'h10;
   localparam logic [7:0] DPT_ADR_SET_FREEZE  = 8'h14;
   localparam logic [7:0] DPT_ADR_RST_FREEZE  = 8'h18;
   localparam logic [7:0] DPT_ADR_IRQ_STATUS  = 8'h1C;
   localparam logic [7:0] DPT_ADR_IRQ_MASK    = 8'h20;

   // -----------------------------------------------------------------
   // Field positions and reset values.
   // -----------------------------------------------------------------
   localparam int          DPT_FREEZE_BIT  = 0;
   localparam int          DPT_CNT_W       = 16;
   localparam logic [15:0] DPT_CNT_RST     = 16'h0000;
   localparam logic [3:0]  DPT_DIV10_LAST  = 4'h9;
   localparam int          DPT_IRQ_W       = 1;

   // -----------------------------------------------------------------
   // Timing: system clock and slow timer clock.
   // -----------------------------------------------------------------
   localparam int DPT_SYS_CLK_HZ  = 25_000_000;
   localparam int DPT_SLOW_CLK_HZ = 32_000;

   // Timer control register, bits 3..0.
   typedef struct packed {
      logic pwm_clocked;
      logic interval_divide_by_ten;
      logic fast_clock_select;
      logic run_control;
   } dpt_ctrl_s;

   // Peripheral clock register, bits 2..0.
   typedef struct packed {
      logic [1:0] timer_clock_divider;
      logic       peripheral_timer_clock_enable;
   } dpt_clkcfg_s;

   // Phase of the cycle counter, Gray coded along idle-high-low.
   typedef enum logic [1:0] {
      DPT_PH_IDLE = 2'b00,
      DPT_PH_HIGH = 2'b01,
      DPT_PH_LOW  = 2'b11
   } dpt_phase_e;

endpackage

//--- rtl/dpt_timer.sv
// Dual output PWM timer with a classic Wishbone register slave.
// Assumes one system clock, synchronous inputs and a level interrupt sink.
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
module dpt_timer
   import dpt_pkg::*;
#(
   parameter int ADDR_W   = 8,
   parameter int CLK_HZ   = DPT_SYS_CLK_HZ,
   parameter int SLOW_HZ  = DPT_SLOW_CLK_HZ
) (
   // Clock, reset and clock enable.
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   // Wishbone slave.
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   // Timer outputs.
   output logic                   pwm_primary_out_o,
   output logic                   pwm_inverted_out_o,
   output logic                   timer_interrupt_o,
   output logic                   irq_o
);

   // -----------------------------------------------------------------
   // Derived constants and elaboration checks.
   // -----------------------------------------------------------------
   localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;

   generate
      if (ADDR_W < 6 || ADDR_W > 8 || SLOW_DIV < 2 || SLOW_DIV > 4095)
      begin : g_bad_param
         $error("dpt_timer: unsupported parameter values");
      end
   endgenerate

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // -----------------------------------------------------------------
   // Functions.
   // -----------------------------------------------------------------
   // Byte-lane merge of a write into a 16-bit register.
   function automatic logic [15:0] wmerge16(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) r[7:0]  = dat[7:0];
      if (sel[1]) r[15:8] = dat[15:8];
      return r;
   endfunction

   // Prescaler mask for a divide by 2**sel.
   function automatic logic [2:0] div_mask(input logic [1:0] sel);
      return 3'((4'h1 << sel) - 4'h1);
   endfunction

   // -----------------------------------------------------------------
   // Registers and state.
   // -----------------------------------------------------------------
   logic [15:0]          high_reload_reg;
   logic [15:0]          low_reload_reg;
   logic [15:0]          interval_reload_reg;
   dpt_ctrl_s            ctrl_reg;
   dpt_clkcfg_s          clkcfg_reg;
   logic                 freeze_reg;
   logic [DPT_IRQ_W-1:0] irq_status_reg;
   logic [DPT_IRQ_W-1:0] irq_mask_reg;
   logic [15:0]          cycle_counter_reg;
   logic [15:0]          interval_counter_reg;
   logic [15:0]          high_shadow_reg;
   logic [15:0]          low_shadow_reg;
   dpt_phase_e           phase_reg;
   logic                 square_reg;
   logic [2:0]           fast_pre_reg;
   logic [11:0]          slow_pre_reg;
   logic [3:0]           div10_reg;

   logic                 req;
   logic                 wr;
   logic                 rd;
   logic [7:0]           badr;
   logic                 active;
   logic                 fast_tick;
   logic                 slow_tick;
   logic                 cyc_tick;
   logic                 ivl_tick;
   logic                 end_cycle;
   logic                 phase_high;

   // -----------------------------------------------------------------
   // Bus decode.
   // -----------------------------------------------------------------
   // A request is taken once, on the edge where ack is raised.
   assign req  = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr   = req && wb_we_i;
   assign rd   = req && !wb_we_i;
   assign badr = 8'({wb_adr_i[ADDR_W-1:2], 2'b00});

   // -----------------------------------------------------------------
   // Timer clock selection.
   // -----------------------------------------------------------------
   // The timer only advances while running, not frozen and enabled.
   assign active    = ce_i && ctrl_reg.run_control && !freeze_reg;
   assign fast_tick = clkcfg_reg.peripheral_timer_clock_enable &&
                      ((fast_pre_reg &
                        div_mask(clkcfg_reg.timer_clock_divider)) ==
                       div_mask(clkcfg_reg.timer_clock_divider));
   assign slow_tick = (slow_pre_reg == 12'(SLOW_DIV - 1));
   assign cyc_tick  = active && (ctrl_reg.fast_clock_select ?
                                 fast_tick : slow_tick);
   assign ivl_tick  = cyc_tick && (!ctrl_reg.interval_divide_by_ten ||
                                   div10_reg == DPT_DIV10_LAST);
   // Idle is the start-up state and counts as the low phase.
   assign end_cycle = cyc_tick && cycle_counter_reg == DPT_CNT_RST &&
                      interval_counter_reg == DPT_CNT_RST &&
                      phase_reg != DPT_PH_HIGH;
   assign phase_high = (phase_reg == DPT_PH_HIGH);

   // Prescalers; cleared while stopped so a start is always aligned.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fast_pre_reg <= 3'h0;
         slow_pre_reg <= 12'h000;
         div10_reg    <= 4'h0;
      end else if (ce_i && !ctrl_reg.run_control) begin
         fast_pre_reg <= 3'h0;
         slow_pre_reg <= 12'h000;
         div10_reg    <= 4'h0;
      end else if (active) begin
         fast_pre_reg <= fast_pre_reg + 3'h1;
         slow_pre_reg <= slow_tick ? 12'h000 : slow_pre_reg + 12'h001;
         if (cyc_tick) begin
            div10_reg <= (div10_reg == DPT_DIV10_LAST) ?
                         4'h0 : div10_reg + 4'h1;
         end
      end
   end

   // -----------------------------------------------------------------
   // Cycle counter, phase and shadows.
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cycle_counter_reg <= DPT_CNT_RST;
         high_shadow_reg   <= DPT_CNT_RST;
         low_shadow_reg    <= DPT_CNT_RST;
         phase_reg         <= DPT_PH_IDLE;
         square_reg        <= 1'b1;
      end else if (ce_i && !ctrl_reg.run_control) begin
         cycle_counter_reg <= DPT_CNT_RST;
         high_shadow_reg   <= DPT_CNT_RST;
         low_shadow_reg    <= DPT_CNT_RST;
         phase_reg         <= DPT_PH_IDLE;
         square_reg        <= 1'b1;
      end else if (end_cycle) begin
         cycle_counter_reg <= high_reload_reg;
         high_shadow_reg   <= high_reload_reg;
         low_shadow_reg    <= low_reload_reg;
         phase_reg         <= DPT_PH_HIGH;
         square_reg        <= 1'b1;
      end else if (cyc_tick) begin
         if (cycle_counter_reg == DPT_CNT_RST) begin
            case (phase_reg)
               DPT_PH_HIGH: begin
                  cycle_counter_reg <= low_shadow_reg;
                  phase_reg         <= DPT_PH_LOW;
               end
               DPT_PH_LOW: begin
                  cycle_counter_reg <= high_shadow_reg;
                  phase_reg         <= DPT_PH_HIGH;
                  square_reg        <= 1'b1;
               end
               default: begin
                  phase_reg <= DPT_PH_IDLE;
               end
            endcase
         end else begin
            cycle_counter_reg <= cycle_counter_reg - 16'h0001;
            square_reg        <= !square_reg;
         end
      end
   end

   // -----------------------------------------------------------------
   // Countdown counter.
   // -----------------------------------------------------------------
   // It parks at zero until the low phase ends, which stretches the
   // last cycle; no interrupt is missed, even with tiny reloads.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         interval_counter_reg <= DPT_CNT_RST;
      end else if (ce_i && !ctrl_reg.run_control) begin
         interval_counter_reg <= DPT_CNT_RST;
      end else if (end_cycle) begin
         interval_counter_reg <= interval_reload_reg;
      end else if (ivl_tick && interval_counter_reg != DPT_CNT_RST) begin
         interval_counter_reg <= interval_counter_reg - 16'h0001;
      end
   end

   // -----------------------------------------------------------------
   // Outputs of the timer.
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwm_primary_out_o  <= 1'b0;
         pwm_inverted_out_o <= 1'b1;
         timer_interrupt_o  <= 1'b0;
      end else if (ce_i) begin
         pwm_primary_out_o  <= phase_high &&
                               (!ctrl_reg.pwm_clocked || square_reg);
         pwm_inverted_out_o <= !(phase_high &&
                               (!ctrl_reg.pwm_clocked || square_reg));
         timer_interrupt_o  <= end_cycle;
      end
   end

   // -----------------------------------------------------------------
   // Software registers.
   // -----------------------------------------------------------------
   // Reload registers survive a disable so software need not rewrite.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         high_reload_reg     <= DPT_CNT_RST;
         low_reload_reg      <= DPT_CNT_RST;
         interval_reload_reg <= DPT_CNT_RST;
         ctrl_reg            <= '0;
         clkcfg_reg          <= '0;
         irq_mask_reg        <= '0;
      end else if (wr) begin
         case (badr)
            DPT_ADR_HIGH_RELOAD:
               high_reload_reg <= wmerge16(high_reload_reg, wb_dat_i,
                                           wb_sel_i);
            DPT_ADR_LOW_RELOAD:
               low_reload_reg <= wmerge16(low_reload_reg, wb_dat_i,
                                          wb_sel_i);
            DPT_ADR_IVL_RELOAD:
               interval_reload_reg <= wmerge16(interval_reload_reg,
                                               wb_dat_i, wb_sel_i);
            DPT_ADR_CONTROL:
               if (wb_sel_i[0]) ctrl_reg <= dpt_ctrl_s'(wb_dat_i[3:0]);
            DPT_ADR_CLK_CFG:
               if (wb_sel_i[0]) clkcfg_reg <= dpt_clkcfg_s'(wb_dat_i[2:0]);
            DPT_ADR_IRQ_MASK:
               if (wb_sel_i[0]) irq_mask_reg <= wb_dat_i[DPT_IRQ_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Freeze is set and cleared through two separate write ports.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         freeze_reg <= 1'b0;
      end else if (wr && wb_sel_i[0] && wb_dat_i[DPT_FREEZE_BIT]) begin
         if (badr == DPT_ADR_SET_FREEZE) begin
            freeze_reg <= 1'b1;
         end else if (badr == DPT_ADR_RST_FREEZE) begin
            freeze_reg <= 1'b0;
         end
      end
   end

   // Sticky status: a read clears it, but a same-cycle event wins.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status_reg <= '0;
      end else if (end_cycle) begin
         irq_status_reg <= '1;
      end else if (rd && badr == DPT_ADR_IRQ_STATUS) begin
         irq_status_reg <= '0;
      end
   end

   // Level interrupt, one clock behind status and mask; frozen with ce_i.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else if (ce_i) begin
         irq_o <= |(irq_status_reg & irq_mask_reg);
      end
   end

   // Single-cycle ack and read data, both registered.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         wb_ack_o <= req;
         if (rd) begin
            case (badr)
               DPT_ADR_HIGH_RELOAD,
               DPT_ADR_LOW_RELOAD:
                  wb_dat_o <= {16'h0000, cycle_counter_reg};
               DPT_ADR_IVL_RELOAD:
                  wb_dat_o <= {16'h0000, interval_counter_reg};
               DPT_ADR_CONTROL:
                  wb_dat_o <= {28'h0000000, ctrl_reg};
               DPT_ADR_CLK_CFG:
                  wb_dat_o <= {29'h00000000, clkcfg_reg};
               DPT_ADR_SET_FREEZE,
               DPT_ADR_RST_FREEZE:
                  wb_dat_o <= {31'h00000000, freeze_reg};
               DPT_ADR_IRQ_STATUS:
                  wb_dat_o <= {31'h00000000, irq_status_reg};
               DPT_ADR_IRQ_MASK:
                  wb_dat_o <= {31'h00000000, irq_mask_reg};
               default:
                  wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // Assertions.
   // -----------------------------------------------------------------
   AST_INVERTED: assert property (
      pwm_inverted_out_o == !pwm_primary_out_o)
      else $error("inverted output is not the complement");

   AST_DISABLED_RESET: assert property (
      (ce_i && !ctrl_reg.run_control) |=>
      cycle_counter_reg == DPT_CNT_RST &&
      interval_counter_reg == DPT_CNT_RST && phase_reg == DPT_PH_IDLE)
      else $error("disabled timer not held in reset state");

   AST_FREEZE_HOLD: assert property (
      (ce_i && freeze_reg && ctrl_reg.run_control && !wr) |=>
      $stable(cycle_counter_reg) && $stable(interval_counter_reg) &&
      $stable(phase_reg))
      else $error("frozen timer state changed");

   AST_END_CYCLE_LOAD: assert property (
      end_cycle |=> timer_interrupt_o &&
      cycle_counter_reg == $past(high_reload_reg) &&
      interval_counter_reg == $past(interval_reload_reg) &&
      phase_reg == DPT_PH_HIGH)
      else $error("end of cycle did not reload and interrupt");

   AST_SHADOW_HOLD: assert property (
      (ce_i && ctrl_reg.run_control && !end_cycle) |=>
      $stable(high_shadow_reg) && $stable(low_shadow_reg))
      else $error("shadow changed outside end of cycle");

   AST_IRQ_PULSE: assert property (
      (timer_interrupt_o && ce_i) |=> !timer_interrupt_o)
      else $error("timer interrupt longer than one clock");

   AST_READ_COUNTDOWN: assert property (
      (rd && badr == DPT_ADR_IVL_RELOAD) |=>
      wb_ack_o && wb_dat_o[15:0] == $past(interval_counter_reg))
      else $error("interval address did not return countdown");

   AST_READ_CYCLE: assert property (
      (rd && badr == DPT_ADR_LOW_RELOAD) |=>
      wb_ack_o && wb_dat_o[15:0] == $past(cycle_counter_reg))
      else $error("phase address did not return cycle counter");

   AST_DECREMENT: assert property (
      (cyc_tick && !end_cycle && cycle_counter_reg != DPT_CNT_RST) |=>
      cycle_counter_reg == $past(cycle_counter_reg) - 16'h0001)
      else $error("cycle counter did not decrement");

   AST_PHASE_SWAP: assert property (
      (cyc_tick && !end_cycle && cycle_counter_reg == DPT_CNT_RST &&
       phase_reg == DPT_PH_HIGH) |=>
      phase_reg == DPT_PH_LOW && cycle_counter_reg == $past(low_shadow_reg))
      else $error("high phase did not swap to low shadow");

endmodule

//--- tb/dpt_timer_bench.sv
// Self-checking bench for the dual output PWM timer.
// Assumes the timer's own assertions and a slow divider of 4 from params.
`timescale 1ns/1ns
module dpt_timer_bench
   import dpt_pkg::*;
;
   // -----------------------------------------------------------------
   // Stimulus and observation signals.
   // -----------------------------------------------------------------
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ce_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o, pri_o, inv_o, tint_o, irq_o, prev_tint;
   int          miscompares = 0;
   int          comparisons = 0;
   int          cyc = 0;
   int          npulse = 0;
   int          hi_acc = 0;
   int          hi_last = 0;
   logic [15:0] m, n, m2;
   logic [31:0] q, v1;
   int          p, c1, c2, c3, np;

   // Slow divider shrunk to 4 cycles so the slow mode finishes quickly.
   dpt_timer #(.ADDR_W(8), .CLK_HZ(2000), .SLOW_HZ(500)) dpt_timer_i (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .pwm_primary_out_o(pri_o),
      .pwm_inverted_out_o(inv_o), .timer_interrupt_o(tint_o),
      .irq_o(irq_o));

   always #20 clk_i = ~clk_i;

   // -----------------------------------------------------------------
   // Helpers.
   // -----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Primary high time per cycle is counted between interrupt pulses.
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      prev_tint <= tint_o;
      if (!rst_i) begin
         check(inv_o, !pri_o);
         if (tint_o === 1'b1 && prev_tint === 1'b1) check(2, 1);
         npulse <= npulse + (tint_o === 1'b1);
         hi_acc <= (tint_o === 1'b1) ? int'(pri_o) : hi_acc + int'(pri_o);
         if (tint_o === 1'b1) hi_last <= hi_acc;
      end
   end

   // Classic single cycle; held until ack is sampled, then released.
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int k;
      k = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      r = wb_dat_o;
      if (k >= 50) check(0, 1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      wb(1'b0, a, 32'h0, r);
   endtask

   task automatic wait_pulse(output int c);
      int k;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (tint_o !== 1'b1 && k < 2000);
      c = cyc;
      if (k >= 2000) check(0, 1);
   endtask

   task automatic meas(output int pr);
      int a, b;
      wait_pulse(a);
      wait_pulse(b);
      pr = b - a;
      @(posedge clk_i);
   endtask

   task automatic results;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Cut a hang short well beyond the expected run length.
   initial begin
      repeat (60000) @(posedge clk_i);
      miscompares++;
      results();
   end

   // -----------------------------------------------------------------
   // Main sequence.
   // -----------------------------------------------------------------
   initial begin
      void'($urandom(32'h585f));
      m  = 16'(2 + $urandom % 8);
      n  = 16'(2 + $urandom % 8);
      m2 = 16'(3 + $urandom % 8);
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         rd((i < 3) ? 8'(i * 4) : 8'h30, q);
         check(q, 32'h0);
      end
      check(pri_o, 1'b0);
      wr(DPT_ADR_HIGH_RELOAD, {16'h0, m});
      wr(DPT_ADR_LOW_RELOAD, {16'h0, n});
      // Fast select without the clock enable must not tick at all.
      wr(DPT_ADR_CONTROL, 32'h3);
      repeat (100) @(posedge clk_i);
      check(npulse, 0);
      wr(DPT_ADR_CLK_CFG, 32'h1);
      wait_pulse(c1);
      repeat (2) @(posedge clk_i);
      check(irq_o, 1'b0);
      wr(DPT_ADR_IRQ_MASK, 32'h1);
      repeat (2) @(posedge clk_i);
      check(irq_o, 1'b1);
      // Every divider setting stretches both phases alike.
      for (int d = 0; d < 4; d++) begin
         wr(DPT_ADR_CLK_CFG, 32'((d << 1) | 1));
         wait_pulse(c1);
         meas(p);
         check(p, (m + n + 2) << d);
         check(hi_last, (m + 1) << d);
      end
      // A reload written mid-cycle waits for the end of the cycle.
      wr(DPT_ADR_CLK_CFG, 32'h1);
      wait_pulse(c1);
      wait_pulse(c1);
      wr(DPT_ADR_HIGH_RELOAD, {16'h0, m2});
      wait_pulse(c2);
      wait_pulse(c3);
      check(c2 - c1, m + n + 2);
      check(c3 - c2, m2 + n + 2);
      wr(DPT_ADR_CONTROL, 32'hB);
      wait_pulse(c1);
      meas(p);
      check(hi_last, (m2 + 2) / 2);
      wr(DPT_ADR_CONTROL, 32'h3);
      wait_pulse(c1);
      wr(DPT_ADR_SET_FREEZE, 32'h1);
      rd(DPT_ADR_HIGH_RELOAD, v1);
      np = npulse;
      repeat (20) @(posedge clk_i);
      rd(DPT_ADR_LOW_RELOAD, q);
      check(q, v1);
      check(npulse, np);
      rd(DPT_ADR_IRQ_STATUS, q);
      check(q, 32'h1);
      rd(DPT_ADR_IRQ_STATUS, q);
      check(q, 32'h0);
      repeat (2) @(posedge clk_i);
      check(irq_o, 1'b0);
      wr(DPT_ADR_RST_FREEZE, 32'h1);
      meas(p);
      check(p, m2 + n + 2);
      // A low clock enable stalls the whole timer for exactly those edges.
      wait_pulse(c1);
      ce_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      ce_i <= 1'b1;
      wait_pulse(c2);
      check(c2 - c1, m2 + n + 22);
      // A long interval holds the end of cycle back.
      wr(DPT_ADR_IVL_RELOAD, 32'd40);
      wait_pulse(c1);
      meas(p);
      check(32'(p >= 41 && p <= 43 + m2 + n), 1);
      rd(DPT_ADR_IVL_RELOAD, q);
      check(32'(q > 21 && q < 40), 1);
      rd(DPT_ADR_HIGH_RELOAD, q);
      check(32'(q <= 16'(m2 > n ? m2 : n)), 1);
      wr(DPT_ADR_IVL_RELOAD, 32'd3);
      wr(DPT_ADR_CONTROL, 32'h7);
      wait_pulse(c1);
      meas(p);
      check(32'(p >= 22 && p <= 42 + m2 + n), 1);
      wr(DPT_ADR_CONTROL, 32'h0);
      repeat (3) @(posedge clk_i);
      check(pri_o, 1'b0);
      rd(DPT_ADR_IVL_RELOAD, q);
      check(q, 32'h0);
      np = npulse;
      repeat (20) @(posedge clk_i);
      check(npulse, np);
      wr(DPT_ADR_IVL_RELOAD, 32'h0);
      wr(DPT_ADR_CONTROL, 32'h1);
      meas(p);
      check(p, 4 * (m2 + n + 2));
      results();
   end
endmodule
